// >>> core/pamux_regs.svh
// Constants of the pin alternate-function multiplexer: field positions,
// pin-mode encodings, serial-mode codes, reset values and strap timing.
// Assumes inclusion by name only; holds definitions and nothing else.
//
// Functional notes
// - Timer2 ch4 drives port_a_bit2 if remap bit7 clear, output enabled, alt output.
// - Timer2 ch4 capture reads port_a_bit2 only while remap bit7 is clear.
// - Port_a_bit2 is serial2 open-drain TWI clock in TWI mode, timer not claiming pin.
// - Serial2 SPI master clock drives port_a_bit2 under the same timer and remap conditions.
// - Serial2 SPI slave clock is taken from port_a_bit2.
// - Serial2 SPI slave select is taken from port_a_bit3 in SPI slave mode.
// - CPU trace clock drives port_a_bit3 when trace on, alt output, timer not claiming.
// - Timer2 ch2 drives port_a_bit3 if remap bit5 clear; capture reads it then too.
// - Port_a_bit4 connects to analog input four when its field selects analog.
// - Packet trace frame drives port_a_bit4 with core trace off, packet trace on.
// - Trace data bit2 drives port_a_bit4 with 4-wire trace selected and enabled.
// - Port_a_bit5 connects to analog input five when its field selects analog.
// - Packet trace data drives port_a_bit5 with core trace off, packet trace on.
// - Low strap on port_a_bit5 around reset starts the factory boot monitor.
// - Trace data bit3 drives port_a_bit5 with 4-wire trace selected and enabled.
// - Timer1 ch3 drives port_a_bit6 when its output enable is set, alt output.
// - Timer1 ch3 capture always reads port_a_bit6, never remapped.
// - Serial1 SPI slave data out drives port_b_bit1 unless timer claims pin.
// - Serial1 SPI master data out drives port_b_bit1 under the same conditions.
// - Port_b_bit1 is serial1 open-drain TWI data in TWI mode, timer not claiming.
// - Serial1 UART transmit drives port_b_bit1 in UART mode, timer not claiming.
// - Serial2 data out on port_a_bit0: push-pull SPI slave, open-drain in TWI.
`ifndef PAMUX_REGS_SVH
`define PAMUX_REGS_SVH

// ****************************************************************
// Pin indices on the pad bus
// ****************************************************************
`define PAMUX_NPINS 7
`define PAMUX_PIN_PA0 0
`define PAMUX_PIN_PA2 1
`define PAMUX_PIN_PA3 2
`define PAMUX_PIN_PA4 3
`define PAMUX_PIN_PA5 4
`define PAMUX_PIN_PA6 5
`define PAMUX_PIN_PB1 6

// ****************************************************************
// Configuration field positions (low bit of each 4-bit field)
// ****************************************************************
`define PAMUX_FLD_PA0 0
`define PAMUX_FLD_PA2 8
`define PAMUX_FLD_PA3 12
`define PAMUX_FLD_PA4 0
`define PAMUX_FLD_PA5 4
`define PAMUX_FLD_PA6 8
`define PAMUX_FLD_PB1 4
`define PAMUX_CFG_RESET 16'h4444

// ****************************************************************
// Pin-mode codes
// ****************************************************************
`define PAMUX_MODE_ANALOG 4'h0
`define PAMUX_MODE_GPIO_PP 4'h1
`define PAMUX_MODE_INPUT 4'h4
`define PAMUX_MODE_GPIO_OD 4'h5
`define PAMUX_MODE_ALT_PP 4'h9
`define PAMUX_MODE_ALT_OD 4'hd

// ****************************************************************
// Timer remap and enable bits, serial controls
// ****************************************************************
`define PAMUX_T2_REMAP_CH4 7
`define PAMUX_T2_REMAP_CH2 5
`define PAMUX_T2_REMAP_SC1 4
`define PAMUX_T2_OE_CH2 1
`define PAMUX_T2_OE_CH4 3
`define PAMUX_T1_OE_CH3 2
`define PAMUX_SPI_MASTER_BIT 4
`define PAMUX_SER_OFF 2'h0
`define PAMUX_SER_UART 2'h1
`define PAMUX_SER_SPI 2'h2
`define PAMUX_SER_TWI 2'h3

// ****************************************************************
// Boot strap timing
// ****************************************************************
`define PAMUX_CLK_PERIOD_NS 100
`define PAMUX_STRAP_HOLD_NS 1000
`define PAMUX_STRAP_CYCLES ((`PAMUX_STRAP_HOLD_NS + `PAMUX_CLK_PERIOD_NS - 1) / `PAMUX_CLK_PERIOD_NS)

`endif

// >>> core/pamux_pkg.sv
// Types shared by the pin multiplexer and its pad stage.
// Assumes the constants header is on the include path.
`include "pamux_regs.svh"

package pamux_pkg;

	// One candidate drive request for a pad
	typedef struct packed {
		logic valid;
		logic od;
		logic data;
	} pamux_alt_t;

	// Trace interface controls from the core
	typedef struct packed {
		logic core_trace_en;
		logic sync4_sel;
		logic packet_trace_en;
	} pamux_trace_t;

	typedef enum logic [2:0] {
		PAMUX_BOOT_RST = 3'b001,
		PAMUX_BOOT_HOLD = 3'b010,
		PAMUX_BOOT_DONE = 3'b100
	} pamux_boot_t;

endpackage

// >>> core/pamux_pin.sv
// Output stage of one pad: GPIO, alternate push-pull or open-drain,
// analog. Assumes the mode field and requests are synchronous to clk.
`timescale 1ns/100ps
`include "pamux_regs.svh"

module pamux_pin (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Selection
	input wire logic [3:0] mode,
	input wire logic force_release,
	input wire pamux_pkg::pamux_alt_t alt,
	input wire logic gpio_data,
	// Pad side
	output logic pad_out,
	output logic pad_oe_n,
	output logic analog_sel
);
	import pamux_pkg::*;

	logic pad_out_nxt;
	logic pad_oe_n_nxt;
	wire is_analog = (mode == `PAMUX_MODE_ANALOG);
	wire is_gpio_pp = (mode == `PAMUX_MODE_GPIO_PP);
	wire is_gpio_od = (mode == `PAMUX_MODE_GPIO_OD);
	wire is_alt = (mode == `PAMUX_MODE_ALT_PP) || (mode == `PAMUX_MODE_ALT_OD);

	// Open-drain drives low only; a high is a released pad
	always_comb begin
		pad_out_nxt = 1'b0;
		pad_oe_n_nxt = 1'b1;
		if (force_release || is_analog) begin
			pad_oe_n_nxt = 1'b1;
		end else if (is_alt && alt.valid) begin
			pad_out_nxt = alt.od ? 1'b0 : alt.data;
			pad_oe_n_nxt = alt.od ? alt.data : 1'b0;
		end else if (is_gpio_pp || is_alt) begin
			pad_out_nxt = gpio_data;
			pad_oe_n_nxt = 1'b0;
		end else if (is_gpio_od) begin
			pad_oe_n_nxt = gpio_data;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			pad_out <= 1'b0;
			pad_oe_n <= 1'b1;
			analog_sel <= 1'b0;
		end else begin
			pad_out <= pad_out_nxt;
			pad_oe_n <= pad_oe_n_nxt;
			analog_sel <= is_analog && !force_release;
		end
	end

endmodule

// >>> core/pamux_top.sv
// Alternate-function multiplexer for seven module pads: selects timer,
// serial, trace, analog or GPIO use and catches the boot strap.
// Assumes all inputs synchronous to clk; pad wires resolved outside.
`timescale 1ns/100ps
`include "pamux_regs.svh"

module pamux_top #(
	parameter int STRAP_CYCLES = `PAMUX_STRAP_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Pads
	input wire logic [`PAMUX_NPINS-1:0] pad_in,
	output logic [`PAMUX_NPINS-1:0] pad_out,
	output logic [`PAMUX_NPINS-1:0] pad_oe_n,
	// Port configuration and GPIO data
	input wire logic [15:0] port_a_low_pin_config,
	input wire logic [15:0] port_a_high_pin_config,
	input wire logic [15:0] port_b_low_pin_config,
	input wire logic [`PAMUX_NPINS-1:0] gpio_out_data,
	output logic [`PAMUX_NPINS-1:0] gpio_in_data,
	// Timers
	input wire logic [7:0] timer_two_remap_option,
	input wire logic [3:0] timer_two_channel_output_enables,
	input wire logic [3:0] timer_one_channel_output_enables,
	input wire logic timer_two_channel_four_out,
	input wire logic timer_two_channel_two_out,
	input wire logic timer_one_channel_three_out,
	output logic timer_two_channel_four_capture,
	output logic timer_two_channel_two_capture,
	output logic timer_one_channel_three_capture,
	// Serial controller 2
	input wire logic [1:0] serial2_mode_select,
	input wire logic [7:0] serial2_spi_config,
	input wire logic serial2_spi_clock_out,
	input wire logic serial2_twi_clock_out,
	input wire logic serial2_data_out,
	output logic serial2_spi_clock_in,
	output logic serial2_spi_slave_select_n,
	output logic serial2_twi_clock_in,
	// Serial controller 1
	input wire logic [1:0] serial1_mode_select,
	input wire logic [7:0] serial1_spi_config,
	input wire logic serial1_spi_slave_out,
	input wire logic serial1_spi_master_out,
	input wire logic serial1_twi_data_out,
	input wire logic serial1_uart_transmit,
	output logic serial1_twi_data_in,
	// Trace
	input wire pamux_pkg::pamux_trace_t trace_ctl,
	input wire logic cpu_trace_clock,
	input wire logic cpu_trace_data_bit2,
	input wire logic cpu_trace_data_bit3,
	input wire logic packet_trace_frame,
	input wire logic packet_trace_serial_data,
	// Analog connections
	output logic analog_input_four,
	output logic analog_input_five,
	// Boot strap
	output logic factory_boot_monitor,
	output logic boot_strap_valid
);
	import pamux_pkg::*;

	// ****************************************************************
	// Elaboration checks
	// ****************************************************************
	generate
		if (STRAP_CYCLES < 1 || STRAP_CYCLES > 255) begin : g_bad_strap
			$error("STRAP_CYCLES must lie in 1..255");
		end
	endgenerate

	// ****************************************************************
	// Pin mode fields
	// ****************************************************************
	wire [3:0] mode_pa0 = port_a_low_pin_config[`PAMUX_FLD_PA0 +: 4];
	wire [3:0] mode_pa2 = port_a_low_pin_config[`PAMUX_FLD_PA2 +: 4];
	wire [3:0] mode_pa3 = port_a_low_pin_config[`PAMUX_FLD_PA3 +: 4];
	wire [3:0] mode_pa4 = port_a_high_pin_config[`PAMUX_FLD_PA4 +: 4];
	wire [3:0] mode_pa5 = port_a_high_pin_config[`PAMUX_FLD_PA5 +: 4];
	wire [3:0] mode_pa6 = port_a_high_pin_config[`PAMUX_FLD_PA6 +: 4];
	wire [3:0] mode_pb1 = port_b_low_pin_config[`PAMUX_FLD_PB1 +: 4];

	wire pa0_pp = (mode_pa0 == `PAMUX_MODE_ALT_PP);
	wire pa0_od = (mode_pa0 == `PAMUX_MODE_ALT_OD);
	wire pa2_pp = (mode_pa2 == `PAMUX_MODE_ALT_PP);
	wire pa2_od = (mode_pa2 == `PAMUX_MODE_ALT_OD);
	wire pa3_pp = (mode_pa3 == `PAMUX_MODE_ALT_PP);
	wire pa4_pp = (mode_pa4 == `PAMUX_MODE_ALT_PP);
	wire pa5_pp = (mode_pa5 == `PAMUX_MODE_ALT_PP);
	wire pa6_pp = (mode_pa6 == `PAMUX_MODE_ALT_PP);
	wire pb1_pp = (mode_pb1 == `PAMUX_MODE_ALT_PP);
	wire pb1_od = (mode_pb1 == `PAMUX_MODE_ALT_OD);

	// ****************************************************************
	// Timer ownership
	// ****************************************************************
	wire remap_ch4 = timer_two_remap_option[`PAMUX_T2_REMAP_CH4];
	wire remap_ch2 = timer_two_remap_option[`PAMUX_T2_REMAP_CH2];
	wire remap_sc1 = timer_two_remap_option[`PAMUX_T2_REMAP_SC1];
	wire t2_ch4_oe = timer_two_channel_output_enables[`PAMUX_T2_OE_CH4];
	wire t2_ch2_oe = timer_two_channel_output_enables[`PAMUX_T2_OE_CH2];
	wire t1_ch3_oe = timer_one_channel_output_enables[`PAMUX_T1_OE_CH3];
	// Timer claims a pad only when enabled and not remapped away
	wire t2_ch4_here = t2_ch4_oe && !remap_ch4;
	wire t2_ch2_here = t2_ch2_oe && !remap_ch2;
	// Port_b_bit1 is released by the timer when its remap bit is clear
	wire pb1_free = !t2_ch4_oe || !remap_sc1;
	wire pa2_free = !t2_ch4_oe || remap_ch4;
	wire pa3_free = !t2_ch2_oe || remap_ch2;

	// ****************************************************************
	// Serial controller modes
	// ****************************************************************
	wire sc2_spi = (serial2_mode_select == `PAMUX_SER_SPI);
	wire sc2_twi = (serial2_mode_select == `PAMUX_SER_TWI);
	wire sc2_master = serial2_spi_config[`PAMUX_SPI_MASTER_BIT];
	wire sc1_spi = (serial1_mode_select == `PAMUX_SER_SPI);
	wire sc1_twi = (serial1_mode_select == `PAMUX_SER_TWI);
	wire sc1_uart = (serial1_mode_select == `PAMUX_SER_UART);
	wire sc1_master = serial1_spi_config[`PAMUX_SPI_MASTER_BIT];

	wire core_trace = trace_ctl.core_trace_en;
	wire sync4_trace = trace_ctl.core_trace_en && trace_ctl.sync4_sel;
	wire pkt_trace = !trace_ctl.core_trace_en && trace_ctl.packet_trace_en;

	// ****************************************************************
	// Drive requests per pad
	// ****************************************************************
	pamux_alt_t alt [`PAMUX_NPINS];
	logic [3:0] mode [`PAMUX_NPINS];
	logic release_pin [`PAMUX_NPINS];
	pamux_boot_t boot_r;
	pamux_boot_t boot_nxt;

	// Port_a_bit0: serial 2 data out
	wire pa0_spi = sc2_spi && !sc2_master && pa0_pp;
	wire pa0_twi = sc2_twi && pa0_od;
	assign alt[`PAMUX_PIN_PA0] = '{valid: pa0_spi || pa0_twi, od: pa0_twi, data: serial2_data_out};

	// Port_a_bit2: timer wins over serial 2 while it owns the pad
	wire pa2_tim = t2_ch4_here && pa2_pp;
	wire pa2_twi = sc2_twi && pa2_od && pa2_free;
	wire pa2_spi = sc2_spi && sc2_master && pa2_pp && pa2_free;
	wire pa2_data = pa2_tim ? timer_two_channel_four_out :
		pa2_twi ? serial2_twi_clock_out : serial2_spi_clock_out;
	assign alt[`PAMUX_PIN_PA2] = '{valid: pa2_tim || pa2_twi || pa2_spi, od: pa2_twi, data: pa2_data};

	// Port_a_bit3: timer channel 2 or CPU trace clock
	wire pa3_tim = t2_ch2_here && pa3_pp;
	wire pa3_trc = core_trace && pa3_pp && pa3_free;
	wire pa3_data = pa3_tim ? timer_two_channel_two_out : cpu_trace_clock;
	assign alt[`PAMUX_PIN_PA3] = '{valid: pa3_tim || pa3_trc, od: 1'b0, data: pa3_data};

	// Port_a_bit4: trace data bit 2 or packet trace frame
	wire pa4_trc = sync4_trace && pa4_pp;
	wire pa4_pkt = pkt_trace && pa4_pp;
	wire pa4_data = pa4_trc ? cpu_trace_data_bit2 : packet_trace_frame;
	assign alt[`PAMUX_PIN_PA4] = '{valid: pa4_trc || pa4_pkt, od: 1'b0, data: pa4_data};

	// Port_a_bit5: trace data bit 3 or packet trace data
	wire pa5_trc = sync4_trace && pa5_pp;
	wire pa5_pkt = pkt_trace && pa5_pp;
	wire pa5_data = pa5_trc ? cpu_trace_data_bit3 : packet_trace_serial_data;
	assign alt[`PAMUX_PIN_PA5] = '{valid: pa5_trc || pa5_pkt, od: 1'b0, data: pa5_data};

	// Port_a_bit6: timer 1 channel 3, high-current pad
	assign alt[`PAMUX_PIN_PA6] = '{valid: t1_ch3_oe && pa6_pp, od: 1'b0, data: timer_one_channel_three_out};

	// Port_b_bit1: serial 1 data out in any of its modes
	wire pb1_slv = sc1_spi && !sc1_master && pb1_pp && pb1_free;
	wire pb1_mst = sc1_spi && sc1_master && pb1_pp && pb1_free;
	wire pb1_twi = sc1_twi && pb1_od && pb1_free;
	wire pb1_uart = sc1_uart && pb1_pp && pb1_free;
	wire pb1_data = pb1_slv ? serial1_spi_slave_out :
		pb1_mst ? serial1_spi_master_out :
		pb1_twi ? serial1_twi_data_out : serial1_uart_transmit;
	assign alt[`PAMUX_PIN_PB1] = '{valid: pb1_slv || pb1_mst || pb1_twi || pb1_uart, od: pb1_twi, data: pb1_data};

	assign mode[`PAMUX_PIN_PA0] = mode_pa0;
	assign mode[`PAMUX_PIN_PA2] = mode_pa2;
	assign mode[`PAMUX_PIN_PA3] = mode_pa3;
	assign mode[`PAMUX_PIN_PA4] = mode_pa4;
	assign mode[`PAMUX_PIN_PA5] = mode_pa5;
	assign mode[`PAMUX_PIN_PA6] = mode_pa6;
	assign mode[`PAMUX_PIN_PB1] = mode_pb1;

	// ****************************************************************
	// Pad stages
	// ****************************************************************
	logic [`PAMUX_NPINS-1:0] analog_sel;

	genvar gi;
	generate
		for (gi = 0; gi < `PAMUX_NPINS; gi++) begin : g_pin
			// Strap pad stays an input until the strap has been taken
			assign release_pin[gi] = (gi == `PAMUX_PIN_PA5) && (boot_r != PAMUX_BOOT_DONE);
			pamux_pin u_pin (
				.clk(clk),
				.rstn(rstn),
				.mode(mode[gi]),
				.force_release(release_pin[gi]),
				.alt(alt[gi]),
				.gpio_data(gpio_out_data[gi]),
				.pad_out(pad_out[gi]),
				.pad_oe_n(pad_oe_n[gi]),
				.analog_sel(analog_sel[gi])
			);
		end
	endgenerate

	assign analog_input_four = analog_sel[`PAMUX_PIN_PA4];
	assign analog_input_five = analog_sel[`PAMUX_PIN_PA5];

	// ****************************************************************
	// Input routing
	// ****************************************************************
	wire in_pa2 = pad_in[`PAMUX_PIN_PA2];
	wire in_pa3 = pad_in[`PAMUX_PIN_PA3];
	wire in_pa6 = pad_in[`PAMUX_PIN_PA6];
	wire in_pb1 = pad_in[`PAMUX_PIN_PB1];
	// Idle levels: capture low, clocks low, selects and TWI lines high
	wire t2c4_cap_nxt = !remap_ch4 && in_pa2;
	wire t2c2_cap_nxt = !remap_ch2 && in_pa3;
	wire sc2_sclk_nxt = sc2_spi && !sc2_master && in_pa2;
	wire sc2_ssel_nxt = !(sc2_spi && !sc2_master) || in_pa3;
	wire sc2_scl_nxt = !sc2_twi || in_pa2;
	wire sc1_sda_nxt = !sc1_twi || in_pb1;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			timer_two_channel_four_capture <= 1'b0;
			timer_two_channel_two_capture <= 1'b0;
			timer_one_channel_three_capture <= 1'b0;
			serial2_spi_clock_in <= 1'b0;
			serial2_spi_slave_select_n <= 1'b1;
			serial2_twi_clock_in <= 1'b1;
			serial1_twi_data_in <= 1'b1;
			gpio_in_data <= '0;
		end else begin
			timer_two_channel_four_capture <= t2c4_cap_nxt;
			timer_two_channel_two_capture <= t2c2_cap_nxt;
			timer_one_channel_three_capture <= in_pa6;
			serial2_spi_clock_in <= sc2_sclk_nxt;
			serial2_spi_slave_select_n <= sc2_ssel_nxt;
			serial2_twi_clock_in <= sc2_scl_nxt;
			serial1_twi_data_in <= sc1_sda_nxt;
			gpio_in_data <= pad_in;
		end
	end

	// ****************************************************************
	// Boot strap capture
	// ****************************************************************
	// Sampled every cycle in reset and for STRAP_CYCLES after release;
	// the last sample decides, so a late-settling strap still counts.
	logic [7:0] hold_cnt_r;
	logic strap_low_r;
	wire hold_last = (hold_cnt_r == 8'(STRAP_CYCLES - 1));

	always_comb begin
		boot_nxt = boot_r;
		case (boot_r)
			PAMUX_BOOT_RST: boot_nxt = PAMUX_BOOT_HOLD;
			PAMUX_BOOT_HOLD: boot_nxt = hold_last ? PAMUX_BOOT_DONE : PAMUX_BOOT_HOLD;
			PAMUX_BOOT_DONE: boot_nxt = PAMUX_BOOT_DONE;
			default: boot_nxt = PAMUX_BOOT_RST;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			boot_r <= PAMUX_BOOT_RST;
			hold_cnt_r <= 8'h00;
		end else begin
			boot_r <= boot_nxt;
			hold_cnt_r <= (boot_r == PAMUX_BOOT_HOLD) ? hold_cnt_r + 8'h01 : 8'h00;
		end
	end

	// Clocked sampling, also while reset is held
	always_ff @(posedge clk) begin
		if (!rstn || boot_r != PAMUX_BOOT_DONE) begin
			strap_low_r <= !pad_in[`PAMUX_PIN_PA5];
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			factory_boot_monitor <= 1'b0;
			boot_strap_valid <= 1'b0;
		end else if (boot_r == PAMUX_BOOT_HOLD && hold_last) begin
			factory_boot_monitor <= strap_low_r;
			boot_strap_valid <= 1'b1;
		end
	end

endmodule

// >>> tb/pamux_pads_model.sv
// Board wiring of the seven pads: pull-ups and external drivers.
// Assumes the bench moves ext_drive and ext_enable off the clock edge.
`timescale 1ns/100ps

module pamux_pads_model (
	// Design side
	input wire logic [6:0] pad_out,
	input wire logic [6:0] pad_oe_n,
	// Board side
	input wire logic [6:0] ext_drive,
	input wire logic [6:0] ext_enable,
	output logic [6:0] pad_in
);
	// ****************************************************************
	// Wire resolution
	// ****************************************************************
	// Pull-up on every pad, so a released pad never keeps a stale level
	wire logic [6:0] dev_level = pad_oe_n | pad_out;
	// Strap and slave inputs come in here, any low driver wins
	wire logic [6:0] ext_level = ~ext_enable | ext_drive;
	assign pad_in = dev_level & ext_level;
endmodule

// >>> tb/pamux_top_sva.sv
// Checker on the ports of the pin multiplexer, bound from the bench.
// Assumes the constants header is on the include path.
`timescale 1ns/100ps
`include "pamux_regs.svh"

module pamux_top_sva #(
	parameter int STRAP_CYCLES = 10
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [`PAMUX_NPINS-1:0] pad_in,
	input wire logic [`PAMUX_NPINS-1:0] pad_out,
	input wire logic [`PAMUX_NPINS-1:0] pad_oe_n,
	input wire logic [15:0] port_a_low_pin_config,
	input wire logic [15:0] port_a_high_pin_config,
	input wire logic [`PAMUX_NPINS-1:0] gpio_out_data,
	input wire logic [7:0] timer_two_remap_option,
	input wire logic [3:0] timer_two_channel_output_enables,
	input wire logic [3:0] timer_one_channel_output_enables,
	input wire logic timer_two_channel_four_out,
	input wire logic timer_one_channel_three_out,
	input wire logic timer_two_channel_four_capture,
	input wire logic timer_one_channel_three_capture,
	input wire logic [1:0] serial2_mode_select,
	input wire logic serial2_twi_clock_out,
	input wire logic analog_input_four,
	input wire logic analog_input_five,
	input wire logic boot_strap_valid
);
	wire logic [3:0] pa2_mode = port_a_low_pin_config[11:8];
	wire logic [3:0] pa6_mode = port_a_high_pin_config[11:8];
	wire logic [7:0] remap = timer_two_remap_option;
	wire logic [3:0] t2oe = timer_two_channel_output_enables;
	// ****************************************************************
	// Properties
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence strap_release;
		rstn && !$past(rstn);
	endsequence
	sequence strap_decide;
		!boot_strap_valid ##STRAP_CYCLES !boot_strap_valid ##1 boot_strap_valid;
	endsequence
	chk_t2c4_drive: assert property (
		pa2_mode == `PAMUX_MODE_ALT_PP && t2oe[3] && !remap[7]
		|=> !pad_oe_n[1] && pad_out[1] == $past(timer_two_channel_four_out))
		else $error("timer ch4 not driven on pad 1");
	chk_t2c4_capture: assert property (
		!remap[7] |=> timer_two_channel_four_capture == $past(pad_in[1]))
		else $error("ch4 capture wrong");
	chk_t2c4_gated: assert property (
		remap[7] |=> !timer_two_channel_four_capture)
		else $error("ch4 capture open");
	chk_twi_clock: assert property (
		serial2_mode_select == `PAMUX_SER_TWI && pa2_mode == `PAMUX_MODE_ALT_OD && (!t2oe[3] || remap[7])
		|=> !pad_out[1] && pad_oe_n[1] == $past(serial2_twi_clock_out))
		else $error("twi clock not open-drain on pad 1");
	chk_analog_four: assert property (
		port_a_high_pin_config[3:0] == `PAMUX_MODE_ANALOG |=> analog_input_four && pad_oe_n[3])
		else $error("pad 3 not handed to analog");
	chk_t1c3_drive: assert property (
		timer_one_channel_output_enables[2] && pa6_mode == `PAMUX_MODE_ALT_PP
		|=> !pad_oe_n[5] && pad_out[5] == $past(timer_one_channel_three_out))
		else $error("timer1 ch3 not driven on pad 5");
	chk_t1c3_capture: assert property (
		rstn |=> timer_one_channel_three_capture == $past(pad_in[5]))
		else $error("ch3 capture wrong");
	chk_gpio_push: assert property (
		pa6_mode == `PAMUX_MODE_GPIO_PP |=> !pad_oe_n[5] && pad_out[5] == $past(gpio_out_data[5]))
		else $error("pad 5 not plain push-pull output");
	chk_strap_release: assert property (
		!boot_strap_valid |-> pad_oe_n[4] && !analog_input_five)
		else $error("strap pad used early");
	chk_strap_time: assert property (
		strap_release |-> strap_decide)
		else $error("strap decision at wrong edge");
endmodule

// >>> tb/pamux_top_tb_top.sv
// Bench for the pin multiplexer: sources on a vector, pads via board model.
// Assumes the package, header and design are compiled first.
`timescale 1ns/100ps

module pamux_top_tb_top;
	import pamux_pkg::*;
	logic clk, rstn;
	logic [15:0] cal, cah, cbl, src;
	logic [7:0] rmp, c2, c1;
	logic [3:0] t2oe, t1oe;
	logic [1:0] m2, m1;
	pamux_trace_t trc;
	logic [6:0] ext_d, ext_e;
	wire logic [6:0] pad_in, pad_out, pad_oe_n, gin, ins;
	wire logic an4, an5, fbm, bsv;
	int mismatches = 0;
	int checks_done = 0;
	int cycles = 0;
	pamux_top #(.STRAP_CYCLES(2)) pamux_top_i (.clk(clk), .rstn(rstn), .pad_in(pad_in), .pad_out(pad_out),
		.pad_oe_n(pad_oe_n), .port_a_low_pin_config(cal), .port_a_high_pin_config(cah),
		.port_b_low_pin_config(cbl), .gpio_out_data({7{src[15]}}), .gpio_in_data(gin),
		.timer_two_remap_option(rmp), .timer_two_channel_output_enables(t2oe),
		.timer_one_channel_output_enables(t1oe), .timer_two_channel_four_out(src[0]),
		.timer_two_channel_two_out(src[1]), .timer_one_channel_three_out(src[2]),
		.timer_two_channel_four_capture(ins[0]), .timer_two_channel_two_capture(ins[1]),
		.timer_one_channel_three_capture(ins[2]), .serial2_mode_select(m2), .serial2_spi_config(c2),
		.serial2_spi_clock_out(src[3]), .serial2_twi_clock_out(src[4]), .serial2_data_out(src[5]),
		.serial2_spi_clock_in(ins[3]), .serial2_spi_slave_select_n(ins[4]), .serial2_twi_clock_in(ins[5]),
		.serial1_mode_select(m1), .serial1_spi_config(c1), .serial1_spi_slave_out(src[6]),
		.serial1_spi_master_out(src[7]), .serial1_twi_data_out(src[8]), .serial1_uart_transmit(src[9]),
		.serial1_twi_data_in(ins[6]), .trace_ctl(trc), .cpu_trace_clock(src[10]),
		.cpu_trace_data_bit2(src[11]), .cpu_trace_data_bit3(src[12]), .packet_trace_frame(src[13]),
		.packet_trace_serial_data(src[14]), .analog_input_four(an4), .analog_input_five(an5),
		.factory_boot_monitor(fbm), .boot_strap_valid(bsv));
	pamux_pads_model pamux_pads_model_i (.pad_out(pad_out), .pad_oe_n(pad_oe_n), .ext_drive(ext_d),
		.ext_enable(ext_e), .pad_in(pad_in));
	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic cmp_bit(input string name, input logic exp, input logic got);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %s expected %0b seen %0b", name, exp, got);
		end
	endtask
	task automatic cmp_vec(input string name, input logic [6:0] exp, input logic [6:0] got);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic step();
		@(posedge clk);
		@(negedge clk);
	endtask
	// Chosen source k alone carries v, all others the inverse
	// Open-drain: level stays low, the enable carries the data
	task automatic drv_pp(input int p, input int k, input bit od = 1'b0);
		for (int v = 0; v < 2; v++) begin
			src = v[0] ? (16'h0001 << k) : ~(16'h0001 << k);
			step();
			cmp_bit("pad enable", od ? v[0] : 1'h0, pad_oe_n[p]);
			cmp_bit("pad level", od ? 1'h0 : v[0], pad_out[p]);
		end
	endtask
	task automatic drv_od(input int p, input int k);
		drv_pp(p, k, 1'b1);
	endtask
	task automatic in_chk(input int p, input int j);
		ext_e[p] = 1'h1;
		for (int v = 0; v < 2; v++) begin
			ext_d[p] = v[0];
			step();
			cmp_bit("input route", v[0], ins[j]);
		end
		ext_e[p] = 1'h0;
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// ****************************************************************
	// Clock, watchdog and sequence
	// ****************************************************************
	initial begin
		clk = 1'h0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			finish_test();
		end
	end
	initial begin
		rstn = 1'h0;
		{cal, cah, cbl} = {3{16'h4444}};
		{src, rmp, c2, c1, t2oe, t1oe, m2, m1} = '0;
		trc = '0;
		ext_d = 7'h00;
		ext_e = 7'h10;
		repeat (16) @(negedge clk);
		cmp_vec("reset enables", 7'h7f, pad_oe_n);
		rstn = 1'h1;
		for (int i = 0; i < 40 && bsv !== 1'h1; i++) step();
		cmp_bit("strap decided", 1'h1, bsv);
		cmp_bit("boot monitor", 1'h1, fbm);
		ext_e = 7'h00;
		step();
		cmp_vec("gpio input copy", 7'h7f, gin);
		cal[11:8] = 4'h9;
		t2oe = 4'h8;
		drv_pp(1, 0);
		cal[11:8] = 4'h4;
		in_chk(1, 0);
		rmp = 8'h80;
		ext_e[1] = 1'h1;
		ext_d[1] = 1'h1;
		step();
		cmp_bit("ch4 remapped", 1'h0, ins[0]);
		ext_e = 7'h00;
		cal[11:8] = 4'hd;
		m2 = 2'h3;
		drv_od(1, 4);
		in_chk(1, 5);
		cal[11:8] = 4'h9;
		m2 = 2'h2;
		c2 = 8'h10;
		drv_pp(1, 3);
		c2 = 8'h00;
		cal[15:8] = 8'h44;
		in_chk(1, 3);
		in_chk(2, 4);
		cal[15:12] = 4'h9;
		trc = 3'h4;
		t2oe = 4'h2;
		rmp = 8'h00;
		drv_pp(2, 1);
		rmp = 8'h20;
		drv_pp(2, 10);
		cal[15:12] = 4'h4;
		rmp = 8'h00;
		in_chk(2, 1);
		cah = 16'h4400;
		step();
		cmp_bit("analog four", 1'h1, an4);
		cmp_bit("analog five", 1'h1, an5);
		cah = 16'h4499;
		trc = 3'h1;
		drv_pp(3, 13);
		drv_pp(4, 14);
		trc = 3'h6;
		drv_pp(3, 11);
		drv_pp(4, 12);
		cah[11:8] = 4'h9;
		t1oe = 4'h4;
		drv_pp(5, 2);
		cah[11:8] = 4'h4;
		in_chk(5, 2);
		cah[11:8] = 4'h1;
		drv_pp(5, 15);
		cah[11:8] = 4'h5;
		drv_od(5, 15);
		cbl[7:4] = 4'h9;
		t2oe = 4'h8;
		m1 = 2'h2;
		drv_pp(6, 6);
		c1 = 8'h10;
		drv_pp(6, 7);
		m1 = 2'h1;
		drv_pp(6, 9);
		rmp = 8'h10;
		drv_pp(6, 15);
		rmp = 8'h00;
		cbl[7:4] = 4'hd;
		m1 = 2'h3;
		drv_od(6, 8);
		in_chk(6, 6);
		cal[3:0] = 4'h9;
		m2 = 2'h2;
		c2 = 8'h00;
		drv_pp(0, 5);
		cal[3:0] = 4'hd;
		m2 = 2'h3;
		drv_od(0, 5);
		finish_test();
	end
endmodule

bind pamux_top pamux_top_sva #(.STRAP_CYCLES(STRAP_CYCLES)) pamux_top_sva_i (.clk, .rstn, .pad_in, .pad_out,
	.pad_oe_n, .port_a_low_pin_config, .port_a_high_pin_config, .gpio_out_data, .timer_two_remap_option,
	.timer_two_channel_output_enables, .timer_one_channel_output_enables, .timer_two_channel_four_out,
	.timer_one_channel_three_out, .timer_two_channel_four_capture, .timer_one_channel_three_capture,
	.serial2_mode_select, .serial2_twi_clock_out, .analog_input_four, .analog_input_five, .boot_strap_valid);
